// ### rtl/dtec_top.sv
// Functional notes
// - Timer function counts once per machine cycle of six clocks.
// - Counter function samples pin each machine cycle, counts on high-then-low samples.
// - Count from a detected fall appears in the following machine cycle.
// - A fall needs two machine cycles, so external rate is clock over twelve maximum.
// - Optionally invert the timer's count pin each time its flag sets; in split mode pin 1 follows timer 0's high byte.
// - Function-select bit picks machine cycles or pin falls as count source.
// - Two-bit mode field gives four modes; mode 3 differs per timer.
// - Mode 0 is a 13-bit counter setting the flag on wrap to zero.
// - Count only while run is set and gate is clear or interrupt pin high; timer 0's split high byte needs only timer 1's run bit.
// - Mode 0 uses high byte plus low five bits; upper three low bits ignored.
// - Setting run resumes counting without clearing the count bytes.
// - Gate select is mode bit 7 for timer 1 and bit 3 for timer 0.
// - Mode 1 is mode 0 with all sixteen bits counting.
// - Mode 2 counts low byte, reloading it from the unchanged high byte.
// - Mode 3 stops timer 1; timer 0 splits, high byte uses timer 1 run and flag.
// - Overflow flags set by hardware, cleared on service or by software.
module dtec_top #(
   parameter int CYCLE_CLOCKS = dtec_pkg::CYCLE_CLOCKS
) (
   input  wire logic                          clock,
   input  wire logic                          rst,
   input  wire logic [7:0]                    timer_mode_register,
   input  wire logic [1:0]                    run_bit,
   input  wire logic [1:0]                    toggle_enable,
   input  wire logic [1:0]                    flag_clear,
   input  wire logic [1:0]                    interrupt_serviced,
   input  wire logic [1:0]                    external_interrupt_pin,
   input  wire dtec_pkg::dtec_write_t         count_write,
   input  wire logic [1:0]                    count_pin_in,
   output logic      [1:0]                    count_pin_out,
   output logic      [1:0]                    count_pin_oe,
   output dtec_pkg::dtec_count_t [1:0]        counts,
   output logic      [1:0]                    overflow_flag
);

   generate
      if (CYCLE_CLOCKS != dtec_pkg::CYCLE_CLOCKS) begin : g_bad_rate
         $error("dtec_top: the machine cycle is fixed at the documented length");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Machine cycle strobe and count pin sampling.

   dtec_pkg::dtec_tmode_t [1:0] tmode;
   logic                        mc_en;
   logic [1:0]                  fall;
   logic [1:0]                  gate_ok;
   logic [1:0]                  tick;
   logic                        split0;
   logic                        high0_tick;

   // Nibble 1 holds timer 1's gate at bit 7, nibble 0 timer 0's gate at bit 3.
   assign tmode = timer_mode_register;

   dtec_cycle_div #(
      .DIVIDE   (CYCLE_CLOCKS)
   ) u_div (
      .clock    (clock),
      .rst      (rst),
      .cycle_en (mc_en)
   );

   for (genvar n = 0; n < dtec_pkg::TIMERS; n++) begin : g_timer
      dtec_fall_detect u_fall (
         .clock    (clock),
         .rst      (rst),
         .cycle_en (mc_en),
         .pin      (count_pin_in[n]),
         .fall     (fall[n])
      );
      assign gate_ok[n] = run_bit[n] & (~tmode[n].gate | external_interrupt_pin[n]);
      // A fall seen at one strobe is counted at the next strobe.
      assign tick[n] = mc_en & gate_ok[n]
                     & (~tmode[n].func_counter | fall[n])
                     & ~((n == 1) && (tmode[n].mode == dtec_pkg::DTEC_MODE_SPLIT));
   end

   assign split0     = (tmode[0].mode == dtec_pkg::DTEC_MODE_SPLIT);
   assign high0_tick = split0 & mc_en & run_bit[1];

   ////////////////////////////////////////////////////////////////////////////
   // Count registers, overflow flags and pin toggles.

   dtec_pkg::dtec_count_t [1:0] next_counts;
   logic [1:0]                  next_flag;
   logic [1:0]                  next_pin_out;
   logic [1:0]                  ovf;
   logic [1:0]                  flag_set;
   logic                        high0_ovf;

   always_comb begin
      dtec_pkg::dtec_count_t c;
      c          = '0;
      ovf        = '0;
      high0_ovf  = 1'b0;
      flag_set   = '0;
      for (int n = 0; n < dtec_pkg::TIMERS; n++) begin
         c = counts[n];
         if (tick[n]) begin
            unique case (tmode[n].mode)
               dtec_pkg::DTEC_MODE_13BIT: begin
                  // The upper three low bits are left alone.
                  if (c.low[4:0] == dtec_pkg::LOW5_ONES) begin
                     ovf[n] = (c.high == dtec_pkg::BYTE_ONES);
                     c.high = c.high + dtec_pkg::BYTE_ONE;
                  end
                  c.low[4:0] = c.low[4:0] + dtec_pkg::LOW5_ONE;
               end
               dtec_pkg::DTEC_MODE_16BIT: begin
                  ovf[n] = (c == {dtec_pkg::BYTE_ONES, dtec_pkg::BYTE_ONES});
                  c      = c + dtec_pkg::WORD_ONE;
               end
               dtec_pkg::DTEC_MODE_RELOAD: begin
                  ovf[n] = (c.low == dtec_pkg::BYTE_ONES);
                  c.low  = ovf[n] ? c.high : c.low + dtec_pkg::BYTE_ONE;
               end
               dtec_pkg::DTEC_MODE_SPLIT: begin
                  ovf[n] = (c.low == dtec_pkg::BYTE_ONES);
                  c.low  = c.low + dtec_pkg::BYTE_ONE;
               end
            endcase
         end
         if ((n == 0) && high0_tick) begin
            high0_ovf = (c.high == dtec_pkg::BYTE_ONES);
            c.high    = c.high + dtec_pkg::BYTE_ONE;
         end
         if (count_write.high_we[n]) begin
            c.high = count_write.data;
         end
         if (count_write.low_we[n]) begin
            c.low = count_write.data;
         end
         next_counts[n] = c;
      end
      // While timer 0 is split, timer 1 keeps counting but its flag belongs
      // to timer 0's high byte.
      flag_set[0] = ovf[0];
      flag_set[1] = (ovf[1] & ~split0) | high0_ovf;
      // A set in the same cycle as a clear wins, so no overflow is lost.
      next_flag    = flag_set | (overflow_flag & ~(flag_clear | interrupt_serviced));
      next_pin_out = count_pin_out ^ (toggle_enable & flag_set);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         counts        <= '0;
         overflow_flag <= '0;
         count_pin_out <= {dtec_pkg::TIMERS{dtec_pkg::PIN_RESET_LEVEL}};
      end else begin
         counts        <= next_counts;
         overflow_flag <= next_flag;
         count_pin_out <= next_pin_out;
      end
   end

   // The pin is only driven while its toggle feature is enabled, so it stays
   // usable as a count input otherwise.
   assign count_pin_oe = toggle_enable;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   logic [15:0] cnt0;
   logic [15:0] cnt1;
   logic        no_wr0;
   logic        no_wr1;

   assign cnt0   = counts[0];
   assign cnt1   = counts[1];
   assign no_wr0 = ~count_write.high_we[0] & ~count_write.low_we[0];
   assign no_wr1 = ~count_write.high_we[1] & ~count_write.low_we[1];

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   chk_cycle_period: assert property (
      mc_en |=> !mc_en [*5] ##1 mc_en)
      else $error("machine cycle strobe not every six clocks");

   chk_timer_step: assert property (
      (mc_en && gate_ok[0] && !tmode[0].func_counter
       && tmode[0].mode == dtec_pkg::DTEC_MODE_16BIT && no_wr0)
      |=> cnt0 == $past(cnt0) + dtec_pkg::WORD_ONE)
      else $error("timer 0 did not advance on machine cycle");

   chk_fall_count: assert property (
      (mc_en && fall[0] && gate_ok[0] && tmode[0].func_counter
       && tmode[0].mode == dtec_pkg::DTEC_MODE_16BIT && no_wr0)
      |=> cnt0 == $past(cnt0) + dtec_pkg::WORD_ONE)
      else $error("detected fall not counted in following machine cycle");

   chk_fall_spacing: assert property (
      $rose(fall[0]) |-> ##6 !fall[0])
      else $error("two falls recognised in consecutive machine cycles");

   chk_gate_hold: assert property (
      (!gate_ok[0] && !split0 && no_wr0) |=> $stable(cnt0))
      else $error("timer 0 counted while not enabled");

   chk_mode0_wrap: assert property (
      (tick[0] && tmode[0].mode == dtec_pkg::DTEC_MODE_13BIT
       && counts[0].high == dtec_pkg::BYTE_ONES
       && counts[0].low[4:0] == dtec_pkg::LOW5_ONES && no_wr0)
      |=> overflow_flag[0] && counts[0].high == '0 && counts[0].low[4:0] == '0)
      else $error("mode 0 wrap did not set the overflow flag");

   chk_reload_value: assert property (
      (tick[0] && tmode[0].mode == dtec_pkg::DTEC_MODE_RELOAD
       && counts[0].low == dtec_pkg::BYTE_ONES && no_wr0)
      |=> counts[0].low == $past(counts[0].high) && $stable(counts[0].high))
      else $error("mode 2 reload wrong");

   chk_t1_stopped: assert property (
      (tmode[1].mode == dtec_pkg::DTEC_MODE_SPLIT && no_wr1) |=> $stable(cnt1))
      else $error("timer 1 counted in mode 3");

   chk_flag_set_wins: assert property (
      flag_set[1] |=> overflow_flag[1])
      else $error("overflow flag lost against a clear");

   chk_pin_toggle: assert property (
      (toggle_enable[0] && flag_set[0]) |=> count_pin_out[0] != $past(count_pin_out[0]))
      else $error("count pin not inverted on overflow");

   chk_write_wins: assert property (
      count_write.low_we[0] |=> counts[0].low == $past(count_write.data))
      else $error("low byte write lost");

endmodule // dtec_top

// ### shared/dtec_pkg.sv
package dtec_pkg;

   // Two timers share one mode byte, one nibble each.
   localparam int TIMERS       = 2;
   localparam int CYCLE_CLOCKS = 6;

   localparam logic [7:0] BYTE_ONES  = 8'hff;
   localparam logic [7:0] BYTE_ONE   = 8'h01;
   localparam logic [4:0] LOW5_ONES  = 5'h1f;
   localparam logic [4:0] LOW5_ONE   = 5'h01;
   localparam logic [15:0] WORD_ONE  = 16'h0001;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic       PIN_RESET_LEVEL = 1'b1;

   typedef enum logic [1:0] {
      DTEC_MODE_13BIT  = 2'h0,
      DTEC_MODE_16BIT  = 2'h1,
      DTEC_MODE_RELOAD = 2'h2,
      DTEC_MODE_SPLIT  = 2'h3
   } dtec_mode_t;

   // One nibble of the timer mode register, most significant field first.
   typedef struct packed {
      logic       gate;
      logic       func_counter;
      dtec_mode_t mode;
   } dtec_tmode_t;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } dtec_count_t;

   typedef struct packed {
      logic [1:0] high_we;
      logic [1:0] low_we;
      logic [7:0] data;
   } dtec_write_t;

endpackage

// ### rtl/dtec_cycle_div.sv
module dtec_cycle_div #(
   parameter int DIVIDE = dtec_pkg::CYCLE_CLOCKS
) (
   input  wire logic clock,
   input  wire logic rst,
   output logic      cycle_en
);

   localparam int W = (DIVIDE > 2) ? $clog2(DIVIDE) : 1;
   localparam logic [W-1:0] LAST = W'(DIVIDE - 1);
   localparam logic [W-1:0] STEP = W'(1);

   generate
      if (DIVIDE < 2) begin : g_bad
         $error("dtec_cycle_div: DIVIDE must be at least 2");
      end
   endgenerate

   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic         next_cycle_en;

   always_comb begin
      next_count    = (count == LAST) ? '0 : count + STEP;
      next_cycle_en = (count == LAST);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count    <= '0;
         cycle_en <= 1'b0;
      end else begin
         count    <= next_count;
         cycle_en <= next_cycle_en;
      end
   end

endmodule // dtec_cycle_div

// ### rtl/dtec_fall_detect.sv
module dtec_fall_detect (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic cycle_en,
   input  wire logic pin,
   output logic      fall
);

   // The pin is looked at once per machine cycle only; the fall flag then
   // stands for the whole following machine cycle.
   logic sample;
   logic next_sample;
   logic next_fall;

   always_comb begin
      next_sample = cycle_en ? pin : sample;
      next_fall   = cycle_en ? (sample & ~pin) : fall;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sample <= 1'b0;
         fall   <= 1'b0;
      end else begin
         sample <= next_sample;
         fall   <= next_fall;
      end
   end

endmodule // dtec_fall_detect

// ### verif/dtec_top_bench.sv
module dtec_top_bench;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {
      string       name;
      logic        st;
      logic [31:0] exp;
      logic [31:0] mask;
   } dtec_note_t;

   localparam logic [31:0] ALL = 32'hffff_ffff;

   logic                        clock = 1'b0;
   logic                        rst   = 1'b1;
   logic [7:0]                  tmr   = 8'h00;
   logic [1:0]                  run   = 2'h0;
   logic [1:0]                  tog   = 2'h2;
   logic [1:0]                  fclr  = 2'h0;
   logic [1:0]                  srv   = 2'h0;
   logic [1:0]                  irq   = 2'h0;
   logic [1:0]                  pin   = 2'h3;
   logic [1:0]                  pout;
   logic [1:0]                  poe;
   logic [1:0]                  flag;
   dtec_pkg::dtec_write_t       cw    = 12'h000;
   dtec_pkg::dtec_count_t [1:0] cnt;
   dtec_note_t                  notes[$];
   int                          error_cnt = 0;
   int                          checks_done = 0;
   int                          cyc = 0;
   logic [7:0]                  r;
   event                        look;

   initial forever #12.5 clock = ~clock;

   // Counts rising edges since reset release, so strobes fall on multiples of six.
   always @(posedge clock or posedge rst) cyc <= rst ? 0 : cyc + 1;

   dtec_top DUT (.clock(clock), .rst(rst), .timer_mode_register(tmr), .run_bit(run),
      .toggle_enable(tog), .flag_clear(fclr), .interrupt_serviced(srv),
      .external_interrupt_pin(irq), .count_write(cw), .count_pin_in(pin),
      .count_pin_out(pout), .count_pin_oe(poe), .counts(cnt), .overflow_flag(flag));

   ////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic note(string name, logic st, logic [31:0] exp, logic [31:0] mask);
      dtec_note_t n;
      n = '{name, st, exp, mask};
      notes.push_back(n);
      ->look;
   endtask

   // Several notes may land in one time step, so the watcher drains the whole queue.
   initial forever begin
      dtec_note_t n;
      @(look);
      while (notes.size() > 0) begin
         n = notes.pop_front();
         check(n.name, (n.st ? {26'h0, flag, pout, poe} : cnt) & n.mask, n.exp & n.mask);
      end
   end

   task automatic cyc_n(int n);
      repeat (n) @(negedge clock);
   endtask

   // The strobe is raised and dropped a cycle apart so it is never assigned twice at once.
   task automatic wr(logic [1:0] hw, logic [1:0] lw, logic [7:0] d);
      cw = {hw, lw, d};
      cyc_n(1);
      cw = 12'h000;
      cyc_n(1);
   endtask

   task automatic load(int t, logic [7:0] hi, logic [7:0] lo);
      wr(2'h1 << t, 2'h0, hi);
      wr(2'h0, 2'h1 << t, lo);
   endtask

   task automatic sync;
      int k;
      k = 0;
      while (cyc % 6 != 0 && k < 7) begin
         cyc_n(1);
         k++;
      end
      if (k == 7) begin
         error_cnt++;
         end_of_test;
      end
   endtask

   task automatic fin(string s);
      $display("test %s done", s);
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      r = $urandom(32'hc790);
      cyc_n(12);
      rst = 1'b0;
      cyc_n(1);
      note("reset counts", 0, 32'h0, ALL);
      note("reset status", 1, 32'h0e, ALL);
      fin("reset");
      r = $urandom;
      wr(2'h3, 2'h0, r);
      wr(2'h0, 2'h3, ~r);
      note("byte write", 0, {r, ~r, r, ~r}, ALL);
      tmr = 8'h11;
      load(0, 8'h00, 8'hfd);
      sync;
      run = 2'h1;
      cyc_n(6);
      // Both bytes are written across a counting edge, so the write has to beat that tick.
      cw = {2'h1, 2'h1, 8'hfd};
      cyc_n(1);
      cw = 12'h000;
      note("write beats count", 0, {r, ~r, 16'hfdfd}, ALL);
      cyc_n(29);
      note("mode1 timer", 0, {r, ~r, 16'hfe01}, ALL);
      run = 2'h0;
      cyc_n(12);
      note("stopped", 0, {r, ~r, 16'hfe01}, ALL);
      run = 2'h1;
      cyc_n(6);
      run = 2'h0;
      note("resumed", 0, {r, ~r, 16'hfe02}, ALL);
      fin("write and timer");
      tmr = 8'h00;
      tog = 2'h3;
      load(0, 8'hff, 8'hff);
      load(1, 8'hff, 8'h1f);
      sync;
      run = 2'h3;
      cyc_n(6);
      run = 2'h0;
      note("mode0 wrap", 0, 32'h0, 32'hff1f_ff1f);
      note("mode0 status", 1, 32'h33, ALL);
      fclr = 2'h1;
      cyc_n(1);
      fclr = 2'h0;
      srv = 2'h2;
      note("soft clear", 1, 32'h20, 32'h30);
      cyc_n(1);
      srv = 2'h0;
      note("service clear", 1, 32'h00, 32'h30);
      fin("mode0");
      tmr = 8'h22;
      tog = 2'h1;
      r = $urandom;
      load(0, 8'h5a, 8'hff);
      load(1, r, 8'hfe);
      sync;
      run = 2'h3;
      cyc_n(12);
      run = 2'h0;
      note("reload", 0, {r, r, 16'h5a5b}, ALL);
      note("reload status", 1, 32'h35, ALL);
      fclr = 2'h3;
      cyc_n(1);
      fclr = 2'h0;
      fin("mode2");
      tmr = 8'h99;
      tog = 2'h0;
      irq = 2'h1;
      wr(2'h3, 2'h3, 8'h00);
      sync;
      run = 2'h3;
      cyc_n(18);
      note("gate t0 open", 0, 32'h0000_0003, ALL);
      irq = 2'h2;
      cyc_n(12);
      run = 2'h0;
      note("gate t1 open", 0, 32'h0002_0003, ALL);
      fin("gate");
      tmr = 8'h55;
      wr(2'h3, 2'h3, 8'h00);
      sync;
      run = 2'h3;
      cyc_n(6);
      pin = 2'h0;
      cyc_n(6);
      note("fall pending", 0, 32'h0, ALL);
      cyc_n(6);
      note("fall counted", 0, 32'h0001_0001, ALL);
      // Each level is held for one full machine cycle, the fastest legal source.
      repeat (3) begin
         pin = 2'h3;
         cyc_n(6);
         pin = 2'h0;
         cyc_n(6);
      end
      note("fast falls", 0, 32'h0003_0003, ALL);
      cyc_n(6);
      run = 2'h0;
      pin = 2'h3;
      note("fast falls end", 0, 32'h0004_0004, ALL);
      fin("counter");
      tmr = 8'h33;
      load(0, 8'hfe, 8'h10);
      load(1, 8'h12, 8'h34);
      sync;
      run = 2'h1;
      cyc_n(12);
      run = 2'h2;
      cyc_n(12);
      run = 2'h0;
      note("split", 0, 32'h1234_0012, ALL);
      note("split flags", 1, 32'h20, 32'h30);
      fin("mode3");
      // Let the watcher drain the last notes before the verdict is printed.
      cyc_n(1);
      end_of_test;
   end
endmodule // dtec_top_bench
